// ==== ppo_pkg.sv ====
// Package with register map, field positions and reset values of the port pin block.
package ppo_pkg;
   localparam int          PPO_PINS         = 8;
   localparam logic [11:0] PPO_ADDR_OUT     = 12'h000;
   localparam logic [11:0] PPO_ADDR_DIR     = 12'h004;
   localparam logic [11:0] PPO_ADDR_PIN     = 12'h008;
   localparam logic [11:0] PPO_ADDR_SFIO    = 12'h00C;
   localparam logic [11:0] PPO_ADDR_EXTINT  = 12'h010;
   localparam logic [11:0] PPO_ADDR_EXTFLAG = 12'h014;
   localparam logic [11:0] PPO_ADDR_EXTMODE = 12'h018;
   localparam int          PPO_SFIO_PUD_BIT = 2;
   localparam logic [7:0]  PPO_SFIO_RST     = 8'h00;
   localparam logic [7:0]  PPO_BYTE_RST     = 8'h00;
   localparam logic [31:0] PPO_RDATA_ZERO   = 32'h0000_0000;
endpackage

// ==== ppo_pin_ctrl.sv ====
// Control logic of one port pin: override muxing, pull-up, input gate and synchronizer.
`timescale 1ns/1ps
`default_nettype none
module ppo_pin_ctrl (
   // Clock and reset.
   input  wire logic pclk,
   input  wire logic presetn,
   // Register bits and shared controls.
   input  wire logic pin_direction_bit,
   input  wire logic pin_output_bit,
   input  wire logic global_pullup_off,
   input  wire logic sleep_clamp,
   input  wire logic extint_en,
   // Override pairs from the owning peripheral.
   input  wire logic pullup_ovr_en,
   input  wire logic pullup_ovr_val,
   input  wire logic dir_ovr_en,
   input  wire logic dir_ovr_val,
   input  wire logic outval_ovr_en,
   input  wire logic outval_ovr_val,
   input  wire logic inen_ovr_en,
   input  wire logic inen_ovr_val,
   // Pad side.
   input  wire logic pad_in,
   output logic      pad_oe,
   output logic      pad_out,
   output logic      pad_pullup,
   // Input side.
   output logic      alt_raw_input,
   output logic      pin_input_bit
);
   logic sync1_r;
   logic sync1_nxt;
   logic sync2_r;
   logic sync2_nxt;
   logic in_en;
   logic pu_reg;

   always_comb begin
      // The drive is cut and the pull-up forced off while reset is low.
      pad_oe  = presetn & (dir_ovr_en ? dir_ovr_val : pin_direction_bit); // see RULE_06 RULE_16 RULE_17
      pad_out = pad_oe & (outval_ovr_en ? outval_ovr_val : pin_output_bit); // see RULE_07 RULE_20
      pu_reg  = ~pin_direction_bit & pin_output_bit & ~global_pullup_off; // see RULE_05 RULE_12
      pad_pullup = presetn & (pullup_ovr_en ? pullup_ovr_val : pu_reg); // see RULE_04 RULE_05
      // An enabled external interrupt keeps the input alive in sleep.
      in_en = inen_ovr_en ? inen_ovr_val : (~sleep_clamp | extint_en); // see RULE_01 RULE_02 RULE_08 RULE_19
      alt_raw_input = pad_in & in_en; // see RULE_09
      sync1_nxt = alt_raw_input;
      sync2_nxt = sync1_r;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_r <= 1'b0;
         sync2_r <= 1'b0;
      end else begin
         sync1_r <= sync1_nxt; // see RULE_18
         sync2_r <= sync2_nxt;
      end
   end

   assign pin_input_bit = sync2_r;
endmodule
`default_nettype wire

// ==== ppo_port.sv ====
// One eight-pin I/O port with APB registers, overrides, sleep clamp and wake flags.
// Summary of operation
// RULE_01 - Sleep clamp grounds digital input before trigger.
// RULE_02 - Enabled external interrupt pins escape the clamp.
// RULE_03 - High disabled edge-mode interrupt pin sets flag on wake.
// RULE_04 - Pull-ups off while reset is active.
// RULE_05 - Pull-up follows override, else dir/out/pud 010.
// RULE_06 - Driver enable follows direction override or bit.
// RULE_07 - Driven value follows value override or bit.
// RULE_08 - Input enable override beats sleep state.
// RULE_09 - Alternate input taken before the synchronizer.
// RULE_10 - Analog path wired straight to the pad.
// RULE_11 - Override pairs come from owning peripherals.
// RULE_12 - Global pull-up disable bit 2 kills pull-ups.
// RULE_13 - Strobes per port; clamp and disable shared.
// RULE_14 - Special function register eight bits, reset zero.
// RULE_15 - Port pins carry external memory address/data.
// RULE_16 - Direction one drives output, zero makes input.
// RULE_17 - Pins tri-state at once on reset.
// RULE_18 - Input bit passes two-stage synchronizer.
// RULE_19 - Disabled input reads zero into synchronizer.
// RULE_20 - Disabled driver leaves pad undriven.
//
// Decided for this implementation: the register offsets and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module ppo_port
   import ppo_pkg::*;
(
   // APB slave.
   input  wire logic                pclk,
   input  wire logic                presetn,
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [11:0]         paddr,
   input  wire logic [31:0]         pwdata,
   output logic      [31:0]         prdata,
   output logic                     pready,
   output logic                     pslverr,
   // Sleep controller.
   input  wire logic                sleep_clamp,
   // Override pairs from peripherals, one bit per pin.
   input  wire logic [PPO_PINS-1:0] pullup_ovr_en,
   input  wire logic [PPO_PINS-1:0] pullup_ovr_val,
   input  wire logic [PPO_PINS-1:0] dir_ovr_en,
   input  wire logic [PPO_PINS-1:0] dir_ovr_val,
   input  wire logic [PPO_PINS-1:0] outval_ovr_en,
   input  wire logic [PPO_PINS-1:0] outval_ovr_val,
   input  wire logic [PPO_PINS-1:0] inen_ovr_en,
   input  wire logic [PPO_PINS-1:0] inen_ovr_val,
   // Pads.
   input  wire logic [PPO_PINS-1:0] pad_in,
   output logic      [PPO_PINS-1:0] pad_oe,
   output logic      [PPO_PINS-1:0] pad_out,
   output logic      [PPO_PINS-1:0] pad_pullup,
   // Inputs toward peripherals.
   output logic      [PPO_PINS-1:0] alt_raw_input,
   output logic      [PPO_PINS-1:0] pin_input_view,
   output logic      [PPO_PINS-1:0] analog_pad_path,
   // Shared pull-up disable for other ports.
   output logic                     global_pullup_off
);
   logic [PPO_PINS-1:0] out_r;
   logic [PPO_PINS-1:0] out_nxt;
   logic [PPO_PINS-1:0] dir_r;
   logic [PPO_PINS-1:0] dir_nxt;
   logic [7:0]          sfio_r;
   logic [7:0]          sfio_nxt;
   logic [PPO_PINS-1:0] exten_r;
   logic [PPO_PINS-1:0] exten_nxt;
   logic [PPO_PINS-1:0] extmode_r;
   logic [PPO_PINS-1:0] extmode_nxt;
   logic [PPO_PINS-1:0] extflag_r;
   logic [PPO_PINS-1:0] extflag_nxt;
   logic                sleep_s1_r;
   logic                sleep_s2_r;
   logic                sleep_d_r;
   logic [PPO_PINS-1:0] pad_s1_r;
   logic [PPO_PINS-1:0] pad_s2_r;
   logic [PPO_PINS-1:0] pin_in;
   logic [PPO_PINS-1:0] high_seen_r;
   logic [PPO_PINS-1:0] high_seen_nxt;
   logic                port_write_strobe;
   logic                dir_write_strobe;
   logic                flag_write_strobe;
   logic                wake;
   logic                wr;

   assign pready  = 1'b1;
   assign pslverr = 1'b0;
   assign wr      = psel & penable & pwrite;
   // Shared strobes for all pins of this port.
   assign port_write_strobe = wr & (paddr == PPO_ADDR_OUT); // see RULE_13
   assign dir_write_strobe  = wr & (paddr == PPO_ADDR_DIR); // see RULE_13
   assign flag_write_strobe = wr & (paddr == PPO_ADDR_EXTFLAG);
   assign global_pullup_off = sfio_r[PPO_SFIO_PUD_BIT]; // see RULE_12 RULE_13
   assign pin_input_view    = pin_in;
   assign wake              = sleep_d_r & ~sleep_s2_r;

   always_comb begin
      out_nxt     = port_write_strobe ? pwdata[PPO_PINS-1:0] : out_r;
      dir_nxt     = dir_write_strobe ? pwdata[PPO_PINS-1:0] : dir_r; // see RULE_16
      sfio_nxt    = (wr & (paddr == PPO_ADDR_SFIO)) ? pwdata[7:0] : sfio_r; // see RULE_14
      exten_nxt   = (wr & (paddr == PPO_ADDR_EXTINT)) ? pwdata[PPO_PINS-1:0] : exten_r;
      extmode_nxt = (wr & (paddr == PPO_ADDR_EXTMODE)) ? pwdata[PPO_PINS-1:0] : extmode_r;
      // A disabled edge pin held high while asleep sees the clamp as an edge.
      high_seen_nxt = sleep_s2_r ? (high_seen_r | (pad_s2_r & ~exten_r & extmode_r)) : '0;
      extflag_nxt = extflag_r;
      if (flag_write_strobe) begin
         extflag_nxt = extflag_r & ~pwdata[PPO_PINS-1:0];
      end
      if (wake) begin
         extflag_nxt = extflag_nxt | high_seen_r; // see RULE_03
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_r       <= PPO_BYTE_RST;
         dir_r       <= PPO_BYTE_RST;
         sfio_r      <= PPO_SFIO_RST; // see RULE_14
         exten_r     <= PPO_BYTE_RST;
         extmode_r   <= PPO_BYTE_RST;
         extflag_r   <= PPO_BYTE_RST;
         high_seen_r <= PPO_BYTE_RST;
         sleep_s1_r  <= 1'b0;
         sleep_s2_r  <= 1'b0;
         sleep_d_r   <= 1'b0;
         pad_s1_r    <= PPO_BYTE_RST;
         pad_s2_r    <= PPO_BYTE_RST;
      end else begin
         out_r       <= out_nxt;
         dir_r       <= dir_nxt;
         sfio_r      <= sfio_nxt;
         exten_r     <= exten_nxt;
         extmode_r   <= extmode_nxt;
         extflag_r   <= extflag_nxt;
         high_seen_r <= high_seen_nxt;
         sleep_s1_r  <= sleep_clamp;
         sleep_s2_r  <= sleep_s1_r;
         sleep_d_r   <= sleep_s2_r;
         pad_s1_r    <= pad_in;
         pad_s2_r    <= pad_s1_r;
      end
   end

   always_comb begin
      prdata = PPO_RDATA_ZERO;
      if (psel & ~pwrite) begin
         unique case (paddr)
            PPO_ADDR_OUT:     prdata[PPO_PINS-1:0] = out_r;
            PPO_ADDR_DIR:     prdata[PPO_PINS-1:0] = dir_r;
            PPO_ADDR_PIN:     prdata[PPO_PINS-1:0] = pin_in;
            PPO_ADDR_SFIO:    prdata[7:0] = sfio_r;
            PPO_ADDR_EXTINT:  prdata[PPO_PINS-1:0] = exten_r;
            PPO_ADDR_EXTFLAG: prdata[PPO_PINS-1:0] = extflag_r;
            PPO_ADDR_EXTMODE: prdata[PPO_PINS-1:0] = extmode_r;
            default:          prdata = PPO_RDATA_ZERO;
         endcase
      end
   end

   // Overrides arrive from the peripherals that own each pin, such as the external memory bus.
   genvar g;
   generate
      for (g = 0; g < PPO_PINS; g++) begin : g_pin
         ppo_pin_ctrl u_pin (
            .pclk              (pclk),
            .presetn           (presetn),
            .pin_direction_bit (dir_r[g]),
            .pin_output_bit    (out_r[g]),
            .global_pullup_off (global_pullup_off),
            .sleep_clamp       (sleep_clamp),
            .extint_en         (exten_r[g]),
            .pullup_ovr_en     (pullup_ovr_en[g]),  // see RULE_11 RULE_15
            .pullup_ovr_val    (pullup_ovr_val[g]),
            .dir_ovr_en        (dir_ovr_en[g]),
            .dir_ovr_val       (dir_ovr_val[g]),
            .outval_ovr_en     (outval_ovr_en[g]),
            .outval_ovr_val    (outval_ovr_val[g]),
            .inen_ovr_en       (inen_ovr_en[g]),
            .inen_ovr_val      (inen_ovr_val[g]),
            .pad_in            (pad_in[g]),
            .pad_oe            (pad_oe[g]),
            .pad_out           (pad_out[g]),
            .pad_pullup        (pad_pullup[g]),
            .alt_raw_input     (alt_raw_input[g]),
            .pin_input_bit     (pin_in[g])
         );
      end
   endgenerate

   // The analog path is the pad level itself, untouched by gating.
   assign analog_pad_path = pad_in; // see RULE_10
endmodule
`default_nettype wire

// ==== ppo_port_sva.sv ====
// Checker of the port block's pad, override and synchronizer behaviour.
`timescale 1ns/1ps
`default_nettype none
module ppo_port_sva
   import ppo_pkg::*;
(
   // Clock and reset.
   input wire logic                pclk,
   input wire logic                presetn,
   // Controls.
   input wire logic                sleep_clamp,
   input wire logic [PPO_PINS-1:0] pullup_ovr_en,
   input wire logic [PPO_PINS-1:0] pullup_ovr_val,
   input wire logic [PPO_PINS-1:0] dir_ovr_en,
   input wire logic [PPO_PINS-1:0] dir_ovr_val,
   input wire logic [PPO_PINS-1:0] outval_ovr_en,
   input wire logic [PPO_PINS-1:0] outval_ovr_val,
   input wire logic [PPO_PINS-1:0] inen_ovr_en,
   input wire logic [PPO_PINS-1:0] inen_ovr_val,
   // Pads and outputs.
   input wire logic [PPO_PINS-1:0] pad_in,
   input wire logic [PPO_PINS-1:0] pad_oe,
   input wire logic [PPO_PINS-1:0] pad_out,
   input wire logic [PPO_PINS-1:0] pad_pullup,
   input wire logic [PPO_PINS-1:0] alt_raw_input,
   input wire logic [PPO_PINS-1:0] pin_input_view,
   input wire logic [PPO_PINS-1:0] analog_pad_path,
   input wire logic                global_pullup_off
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_dir; (pad_oe & dir_ovr_en) == (dir_ovr_val & dir_ovr_en); endproperty
   a_dir: assert property (p_dir) else $error("driver enable ignores override");
   property p_pu; (pad_pullup & pullup_ovr_en) == (pullup_ovr_val & pullup_ovr_en); endproperty
   a_pu: assert property (p_pu) else $error("pull-up ignores override");
   property p_pud; global_pullup_off |-> (pad_pullup & ~pullup_ovr_en) == '0; endproperty
   a_pud: assert property (p_pud) else $error("pull-up on while disabled");
   property p_val; (pad_out & pad_oe & outval_ovr_en) == (outval_ovr_val & pad_oe & outval_ovr_en);
   endproperty
   a_val: assert property (p_val) else $error("value ignores override");
   property p_hiz; (pad_out & ~pad_oe) == '0; endproperty
   a_hiz: assert property (p_hiz) else $error("value driven while off");
   property p_ana; analog_pad_path == pad_in; endproperty
   a_ana: assert property (p_ana) else $error("analog path differs from pad");
   property p_ien; (alt_raw_input & inen_ovr_en) == (pad_in & inen_ovr_val & inen_ovr_en);
   endproperty
   a_ien: assert property (p_ien) else $error("input enable ignores override");
   property p_sync;
      (!sleep_clamp && inen_ovr_en == '0 && $stable(pad_in))[*3] |-> pin_input_view == pad_in;
   endproperty
   a_sync: assert property (p_sync) else $error("synced input wrong");
   c_wake: cover property (sleep_clamp ##1 !sleep_clamp);
   c_dovr: cover property (|dir_ovr_en);
   c_pud: cover property (global_pullup_off);
endmodule
bind ppo_port ppo_port_sva u_sva (.*);
`default_nettype wire

// ==== ppo_pad_model.sv ====
// Pad model: external drivers, pull-up and floating level of each pin.
`timescale 1ns/1ps
`default_nettype none
module ppo_pad_model (
   // Clock.
   input  wire logic       pclk,
   // Pad controls and external drive.
   input  wire logic [7:0] pad_oe,
   input  wire logic [7:0] pad_out,
   input  wire logic [7:0] pad_pullup,
   input  wire logic [7:0] ext_en,
   input  wire logic [7:0] ext_val,
   // Resolved level.
   output logic      [7:0] pad_in
);
   logic [7:0] float_r = 8'h55;
   always_ff @(posedge pclk) float_r <= ~float_r;
   assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_val)
                 | (~pad_oe & ~ext_en & (pad_pullup | float_r));
endmodule
`default_nettype wire

// ==== ppo_port_test.sv ====
// Self-checking bench of the port block over APB.
`timescale 1ns/1ps
`default_nettype none
module ppo_port_test;
   import ppo_pkg::*;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic sleep_clamp = 1'b0, pready, pslverr, global_pullup_off;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
   logic [7:0] pullup_ovr_en = 8'h00, pullup_ovr_val = 8'h00, dir_ovr_en = 8'h00;
   logic [7:0] dir_ovr_val = 8'h00, outval_ovr_en = 8'h00, outval_ovr_val = 8'h00;
   logic [7:0] inen_ovr_en = 8'h00, inen_ovr_val = 8'h00, ext_en = 8'hFF, ext_val = 8'h00;
   logic [7:0] pad_in, pad_oe, pad_out, pad_pullup, alt_raw_input, pin_input_view;
   logic [7:0] analog_pad_path, d, o;
   int mismatches = 0, n_compared = 0;
   ppo_port uut (.*);
   ppo_pad_model u_pad (.*);
   always #20 pclk = ~pclk;
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic complete_run;
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] v);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h00_0000, v};
      @(posedge pclk) penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         mismatches++;
         complete_run();
      end
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic rdchk(input logic [11:0] a, input logic [7:0] exp);
      apb(1'b0, a, 8'h00);
      chk(rd[7:0], exp);
   endtask
   initial begin
      repeat (16) @(posedge pclk);
      chk(pad_oe, 8'h00);
      chk(pad_pullup, 8'h00);
      presetn <= 1'b1;
      rdchk(PPO_ADDR_SFIO, PPO_SFIO_RST);
      apb(1'b1, PPO_ADDR_SFIO, 8'hFF);
      rdchk(PPO_ADDR_SFIO, 8'hFF);
      rdchk(12'h020, 8'h00);
      chk({7'h00, pslverr}, 8'h00);
      $display("registers done");
      for (int i = 0; i < 8; i++) begin
         apb(1'b1, PPO_ADDR_DIR, {8{i[2]}});
         apb(1'b1, PPO_ADDR_OUT, {8{i[1]}});
         apb(1'b1, PPO_ADDR_SFIO, {5'h00, i[0], 2'h0});
         chk({7'h00, global_pullup_off}, {7'h00, i[0]});
         chk(pad_pullup, {8{i == 2}});
         chk(pad_oe, {8{i[2]}});
         chk(pad_out, {8{i[2] & i[1]}});
      end
      $display("configuration table done");
      d = 8'h0F;
      o = 8'h33;
      apb(1'b1, PPO_ADDR_DIR, d);
      apb(1'b1, PPO_ADDR_OUT, o);
      apb(1'b1, PPO_ADDR_SFIO, 8'h00);
      dir_ovr_en <= 8'h3C;
      dir_ovr_val <= 8'h18;
      outval_ovr_en <= 8'h66;
      outval_ovr_val <= 8'h42;
      pullup_ovr_en <= 8'h81;
      pullup_ovr_val <= 8'h01;
      @(negedge pclk);
      chk(pad_oe, (dir_ovr_en & dir_ovr_val) | (~dir_ovr_en & d));
      chk(pad_out, pad_oe & ((outval_ovr_en & outval_ovr_val) | (~outval_ovr_en & o)));
      chk(pad_pullup, (pullup_ovr_en & pullup_ovr_val) | (~pullup_ovr_en & ~d & o));
      $display("overrides done");
      @(posedge pclk);
      dir_ovr_en <= 8'h00;
      outval_ovr_en <= 8'h00;
      pullup_ovr_en <= 8'h00;
      ext_val <= 8'hA5;
      apb(1'b1, PPO_ADDR_DIR, 8'h00);
      repeat (3) @(posedge pclk);
      rdchk(PPO_ADDR_PIN, 8'hA5);
      chk(alt_raw_input, 8'hA5);
      chk(pin_input_view, 8'hA5);
      chk(analog_pad_path, 8'hA5);
      apb(1'b1, PPO_ADDR_EXTMODE, 8'hFF);
      apb(1'b1, PPO_ADDR_EXTINT, 8'h01);
      sleep_clamp <= 1'b1;
      @(negedge pclk);
      chk(alt_raw_input, 8'h01);
      @(posedge pclk);
      inen_ovr_en <= 8'h80;
      inen_ovr_val <= 8'h80;
      @(negedge pclk);
      chk(alt_raw_input, 8'h81);
      repeat (4) @(posedge pclk);
      chk(pin_input_view, 8'h81);
      sleep_clamp <= 1'b0;
      repeat (6) @(posedge pclk);
      rdchk(PPO_ADDR_EXTFLAG, 8'hA4);
      apb(1'b1, PPO_ADDR_EXTFLAG, 8'hFF);
      rdchk(PPO_ADDR_EXTFLAG, 8'h00);
      $display("sleep and wake done");
      apb(1'b1, PPO_ADDR_DIR, 8'hF0);
      apb(1'b1, PPO_ADDR_OUT, 8'h0F);
      chk(pad_pullup, 8'h0F);
      ext_en <= 8'h00;
      repeat (3) @(posedge pclk);
      rdchk(PPO_ADDR_PIN, 8'h0F);
      @(posedge pclk) presetn <= 1'b0;
      #1;
      chk(pad_pullup, 8'h00);
      chk(pad_oe, 8'h00);
      $display("reset done");
      complete_run();
   end
endmodule
`default_nettype wire
